// ===== hdl/sctl_pkg.sv
// sctl_pkg: register map, field layout and codes of the system configuration block
package sctl_pkg;

   localparam int unsigned SCTL_ADDR_W    = 12;
   localparam int unsigned SCTL_DATA_W    = 32;
   localparam int unsigned SCTL_LINES     = 16;
   localparam int unsigned SCTL_PORTS     = 9;
   localparam int unsigned SCTL_FIELD_W   = 4;
   localparam int unsigned SCTL_SRC_REGS  = 4;
   localparam int unsigned SCTL_SRC_W     = 16;

   // register byte offsets
   localparam logic [11:0] SCTL_OFF_PMCFG  = 12'h004;
   localparam logic [11:0] SCTL_OFF_SRC0   = 12'h008;
   localparam logic [11:0] SCTL_OFF_SRC1   = 12'h00c;
   localparam logic [11:0] SCTL_OFF_SRC2   = 12'h010;
   localparam logic [11:0] SCTL_OFF_SRC3   = 12'h014;
   localparam logic [11:0] SCTL_OFF_CCCTRL = 12'h020;

   // field positions
   localparam int unsigned SCTL_PHY_SEL_BIT  = 23;
   localparam int unsigned SCTL_COMP_PWR_BIT = 0;
   localparam int unsigned SCTL_COMP_RDY_BIT = 8;

   // readable bits of each register, everything else reads as zero
   localparam logic [31:0] SCTL_MASK_PMCFG  = 32'h0080_0000;
   localparam logic [31:0] SCTL_MASK_SRC    = 32'h0000_ffff;
   localparam logic [31:0] SCTL_MASK_CCCTRL = 32'h0000_0101;

   // reset values
   localparam logic        SCTL_RST_PHY_SEL  = 1'b0;
   localparam logic [15:0] SCTL_RST_SRC      = 16'h0000;
   localparam logic        SCTL_RST_COMP_PWR = 1'b0;
   localparam logic [31:0] SCTL_RST_WORD     = 32'h0000_0000;

   // line source codes
   localparam logic [3:0] SCTL_CODE_PORT_A = 4'h0;
   localparam logic [3:0] SCTL_CODE_PORT_H = 4'h7;
   localparam logic [3:0] SCTL_CODE_PORT_I = 4'h8;

   // lines from this index up have no port I pin
   localparam int unsigned SCTL_FIRST_LINE_NO_PORT_I = 12;

   typedef enum logic [2:0] {
      SCTL_SEL_NONE,
      SCTL_SEL_PMCFG,
      SCTL_SEL_SRC,
      SCTL_SEL_CCCTRL
   } sctl_reg_sel_type;

endpackage

// ===== hdl/sctl_line_mux.sv
// sctl_line_mux: picks pin n of the selected port for one interrupt line
`timescale 1ns/10ps
module sctl_line_mux
   import sctl_pkg::*;
#(
   parameter bit PORT_I_PRESENT = 1'b1
)(
   input  wire logic [3:0] sel,
   input  wire logic [8:0] pins,
   output wire logic       level
);

   wire logic [3:0]  last_code;
   wire logic        sel_ok;
   wire logic [15:0] padded;

   // port I is dropped for the upper lines, so its code falls back to reserved [R8]
   assign last_code = PORT_I_PRESENT ? SCTL_CODE_PORT_I : SCTL_CODE_PORT_H;
   // codes above the last port are reserved and give a quiet low level [R3]
   assign sel_ok    = (sel <= last_code);
   // padding keeps the index in range for every 4-bit code
   assign padded    = {7'h00, pins};
   assign level     = sel_ok & padded[sel];

endmodule

// ===== hdl/sctl_system_config.sv
// sctl_system_config: apb register bank for phy select, line sources and compensation cell
//
// How it works
// R1: bit 23 of the peripheral mode register selects mii (0) or rmii (1).
// R2: software changes phy select only while ethernet is in reset, clock off.
// R3: a 4-bit line source code 0..8 picks port a..i; other codes reserved.
// R4: offset 0x08 holds sources of lines 0-3; bits 31:16 read zero.
// R5: offset 0x0c holds sources of lines 4-7 in ascending 4-bit fields.
// R6: offset 0x10 holds sources of lines 8-11 in ascending 4-bit fields.
// R7: offset 0x14 holds sources of lines 12-15 in ascending 4-bit fields.
// R8: lines 12-15 treat the port i code as reserved.
// R9: compensation bit 0 powers the cell down at 0, enables at 1.
// R10: compensation bit 8 is read-only and reports cell ready.
// R11: every register resets to zero: mii, port a sources, cell powered down.
// R12: reserved bits read zero and ignore writes.
// R13: each line n drives out pin n of the port its field selects.
`timescale 1ns/10ps
module sctl_system_config
   import sctl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output wire logic        pready,
   output wire logic        pslverr,
   output logic      [31:0] prdata,
   input  wire logic [15:0] port_a_pin,
   input  wire logic [15:0] port_b_pin,
   input  wire logic [15:0] port_c_pin,
   input  wire logic [15:0] port_d_pin,
   input  wire logic [15:0] port_e_pin,
   input  wire logic [15:0] port_f_pin,
   input  wire logic [15:0] port_g_pin,
   input  wire logic [15:0] port_h_pin,
   input  wire logic [15:0] port_i_pin,
   output logic      [15:0] line_level,
   output logic             phy_interface_select,
   output logic             comp_cell_power_enable,
   input  wire logic        comp_cell_ready
);

   // pick field idx out of the packed line source registers
   function automatic logic [3:0] field_of(input logic [63:0] all, input int unsigned idx);
      field_of = all[idx*SCTL_FIELD_W +: SCTL_FIELD_W];
   endfunction

   logic             phy_sel_q;
   logic      [15:0] src0_q;
   logic      [15:0] src1_q;
   logic      [15:0] src2_q;
   logic      [15:0] src3_q;
   logic             comp_pwr_q;
   logic             comp_rdy_q;
   logic      [31:0] prdata_q;
   logic      [31:0] rd_word_c;
   logic      [31:0] rd_mask_c;
   logic      [15:0] line_level_q;
   wire logic [15:0] line_level_d;

   wire logic        hit_pmcfg;
   wire logic [3:0]  hit_src;
   wire logic        hit_ccctrl;
   wire logic        addr_hit;
   wire logic        setup_rd;
   wire logic        access;
   wire logic        wr_en;
   wire logic [63:0] src_all;
   wire logic [31:0] rd_pmcfg;
   wire logic [31:0] rd_src;
   wire logic [31:0] rd_ccctrl;
   wire logic [31:0] rd_word;
   wire logic [31:0] rd_mask;
   wire sctl_reg_sel_type reg_sel;

   // address decode, exact word match so misaligned addresses count as unmapped
   assign hit_pmcfg  = (paddr == SCTL_OFF_PMCFG);
   assign hit_src[0] = (paddr == SCTL_OFF_SRC0);
   assign hit_src[1] = (paddr == SCTL_OFF_SRC1);
   assign hit_src[2] = (paddr == SCTL_OFF_SRC2);
   assign hit_src[3] = (paddr == SCTL_OFF_SRC3);
   assign hit_ccctrl = (paddr == SCTL_OFF_CCCTRL);
   assign addr_hit   = hit_pmcfg | (|hit_src) | hit_ccctrl;
   assign reg_sel    = sctl_reg_sel_type'(hit_pmcfg  ? SCTL_SEL_PMCFG  :
                                          (|hit_src) ? SCTL_SEL_SRC    :
                                          hit_ccctrl ? SCTL_SEL_CCCTRL : SCTL_SEL_NONE);

   // zero wait state: read data is captured in setup, so access always completes
   assign pready   = 1'b1;
   assign access   = psel & penable;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign wr_en    = access & pwrite & pready;
   // unmapped addresses answer with an error; writes there change nothing
   assign pslverr  = access & ~addr_hit;

   assign src_all = {src3_q, src2_q, src1_q, src0_q};

   // read words, reserved positions built as zero [R12]
   assign rd_pmcfg  = {{(31 - SCTL_PHY_SEL_BIT){1'b0}}, phy_sel_q,
                       {SCTL_PHY_SEL_BIT{1'b0}}};
   // upper half of each source register is reserved [R4]
   assign rd_src    = hit_src[0] ? {16'h0000, src0_q} :
                      hit_src[1] ? {16'h0000, src1_q} :
                      hit_src[2] ? {16'h0000, src2_q} :
                                   {16'h0000, src3_q};
   // ready flag sits at bit 8, eight bits above the power bit, and has no write path [R10]
   assign rd_ccctrl = {{(31 - SCTL_COMP_RDY_BIT){1'b0}}, comp_rdy_q,
                       {(SCTL_COMP_RDY_BIT - 1){1'b0}}, comp_pwr_q};

   always_comb begin
      case (reg_sel)
         SCTL_SEL_PMCFG:  begin
            rd_word_c = rd_pmcfg;
            rd_mask_c = SCTL_MASK_PMCFG;
         end
         SCTL_SEL_SRC:    begin
            rd_word_c = rd_src;
            rd_mask_c = SCTL_MASK_SRC;
         end
         SCTL_SEL_CCCTRL: begin
            rd_word_c = rd_ccctrl;
            rd_mask_c = SCTL_MASK_CCCTRL;
         end
         default:         begin
            rd_word_c = SCTL_RST_WORD;
            rd_mask_c = SCTL_RST_WORD;
         end
      endcase
   end

   assign rd_word = rd_word_c & rd_mask_c;
   assign rd_mask = rd_mask_c;

   // peripheral mode register; only bit 23 is stored [R1] [R12]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phy_sel_q <= SCTL_RST_PHY_SEL;                   // [R11]
      end else if (wr_en && hit_pmcfg) begin
         phy_sel_q <= pwdata[SCTL_PHY_SEL_BIT];           // [R1]
      end
   end

   // line source registers keep their low half only [R12]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src0_q <= SCTL_RST_SRC;                          // [R11]
         src1_q <= SCTL_RST_SRC;
         src2_q <= SCTL_RST_SRC;
         src3_q <= SCTL_RST_SRC;
      end else if (wr_en) begin
         if (hit_src[0]) src0_q <= pwdata[15:0];          // [R4]
         if (hit_src[1]) src1_q <= pwdata[15:0];          // [R5]
         if (hit_src[2]) src2_q <= pwdata[15:0];          // [R6]
         if (hit_src[3]) src3_q <= pwdata[15:0];          // [R7]
      end
   end

   // compensation cell power bit, plus a flop on the cell's ready level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_pwr_q <= SCTL_RST_COMP_PWR;                 // [R11]
         comp_rdy_q <= 1'b0;
      end else begin
         if (wr_en && hit_ccctrl) begin
            comp_pwr_q <= pwdata[SCTL_COMP_PWR_BIT];      // [R9]
         end
         comp_rdy_q <= comp_cell_ready;                   // [R10]
      end
   end

   // read data is sampled at setup so prdata comes from a flop during access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= SCTL_RST_WORD;
      end else if (setup_rd) begin
         prdata_q <= rd_word;                             // [R12]
      end
   end

   // one mux per line; port i is wired to every line but only selectable on the lower twelve lines
   genvar gi;
   generate
      for (gi = 0; gi < SCTL_LINES; gi++) begin : g_line
         wire logic [8:0] pins_at_line;
         assign pins_at_line = {port_i_pin[gi], port_h_pin[gi], port_g_pin[gi],
                                port_f_pin[gi], port_e_pin[gi], port_d_pin[gi],
                                port_c_pin[gi], port_b_pin[gi], port_a_pin[gi]};
         sctl_line_mux #(
            .PORT_I_PRESENT (gi < SCTL_FIRST_LINE_NO_PORT_I)
         ) u_mux (
            .sel   (field_of(src_all, gi)),
            .pins  (pins_at_line),
            .level (line_level_d[gi])
         );
      end
   endgenerate

   // line levels are registered, one cycle behind the pins [R13]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_level_q <= SCTL_RST_SRC;
      end else begin
         line_level_q <= line_level_d;                    // [R13]
      end
   end

   assign prdata                 = prdata_q;
   assign line_level             = line_level_q;
   // switching this while the mac runs would glitch its clocking, software guards it [R2]
   assign phy_interface_select   = phy_sel_q;
   assign comp_cell_power_enable = comp_pwr_q;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_wr_at(logic hit);
      wr_en && hit;
   endsequence

   sequence s_rd_setup(logic hit);
      setup_rd && hit;
   endsequence

   AST_PHY_SEL: assert property (                          // [R1]
      s_wr_at(hit_pmcfg) |=> phy_interface_select == $past(pwdata[SCTL_PHY_SEL_BIT]))
      else $error("phy select did not follow write");

   AST_PHY_HOLD: assert property (                         // [R1]
      !(wr_en && hit_pmcfg) |=> $stable(phy_interface_select))
      else $error("phy select changed without a write");

   AST_SRC0: assert property (                             // [R4]
      s_rd_setup(hit_src[0]) |=> prdata == {16'h0000, $past(src0_q)})
      else $error("lines 0-3 source readback wrong");

   AST_SRC1: assert property (                             // [R5]
      s_wr_at(hit_src[1]) |=> src1_q == $past(pwdata[15:0]))
      else $error("lines 4-7 source not stored");

   AST_SRC2: assert property (                             // [R6]
      s_wr_at(hit_src[2]) |=> src2_q == $past(pwdata[15:0]) && $stable(src1_q))
      else $error("lines 8-11 source not stored");

   AST_SRC3: assert property (                             // [R7]
      s_wr_at(hit_src[3]) |=> src3_q == $past(pwdata[15:0]) && $stable(src2_q))
      else $error("lines 12-15 source not stored");

   AST_COMP_PWR: assert property (                         // [R9]
      s_wr_at(hit_ccctrl) |=> comp_cell_power_enable == $past(pwdata[SCTL_COMP_PWR_BIT]))
      else $error("compensation power bit did not follow write");

   AST_COMP_RDY: assert property (                         // [R10]
      s_rd_setup(hit_ccctrl) ##1 access |-> prdata[SCTL_COMP_RDY_BIT] == $past(comp_rdy_q))
      else $error("ready flag readback wrong");

   AST_RESET_ZERO: assert property (                       // [R11]
      $rose(presetn) |-> !phy_interface_select && !comp_cell_power_enable && src_all == 64'h0)
      else $error("registers not zero after reset");

   AST_RESERVED_ZERO: assert property (                    // [R12]
      s_rd_setup(addr_hit) |=> (prdata & ~$past(rd_mask)) == SCTL_RST_WORD &&
         $past(rd_mask) == ($past(hit_pmcfg)  ? SCTL_MASK_PMCFG  :
                            $past(hit_ccctrl) ? SCTL_MASK_CCCTRL : SCTL_MASK_SRC))
      else $error("reserved bits read nonzero");

   generate
      for (gi = 0; gi < SCTL_LINES; gi++) begin : g_chk
         // the release edge itself still loads zero into the line flops, so start after it
         AST_LINE_PORT_A: assert property (                // [R3] [R13]
            presetn && field_of(src_all, gi) == SCTL_CODE_PORT_A |=>
               line_level[gi] == $past(port_a_pin[gi]))
            else $error("line does not follow port a pin");

         AST_LINE_PORT_H: assert property (                // [R3] [R13]
            presetn && field_of(src_all, gi) == SCTL_CODE_PORT_H |=>
               line_level[gi] == $past(port_h_pin[gi]))
            else $error("line does not follow port h pin");

         AST_LINE_RESERVED: assert property (              // [R3]
            field_of(src_all, gi) > SCTL_CODE_PORT_I |=> !line_level[gi])
            else $error("reserved code drove a line high");

         if (gi >= SCTL_FIRST_LINE_NO_PORT_I) begin : g_upper
            AST_PORTI_UPPER: assert property (             // [R8]
               field_of(src_all, gi) == SCTL_CODE_PORT_I |=> !line_level[gi])
               else $error("port i code used on an upper line");
         end else begin : g_lower
            AST_PORTI_LOWER: assert property (             // [R3]
               presetn && field_of(src_all, gi) == SCTL_CODE_PORT_I |=>
                  line_level[gi] == $past(port_i_pin[gi]))
               else $error("line does not follow port i pin");
         end
      end
   endgenerate

endmodule

// ===== sim/sctl_system_config_bench.sv
// sctl_system_config_bench: self-checking apb bench of the system configuration block
`timescale 1ns/10ps
module sctl_system_config_bench
   import sctl_pkg::*;
;
   typedef struct {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] r;
      logic        e;
   } sctl_row_type;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic [15:0] pin [9];
   logic [15:0] line_level;
   logic        phy_interface_select;
   logic        comp_cell_power_enable;
   logic        comp_cell_ready;
   logic [31:0] rd;
   logic        er;
   logic [15:0] src [4];
   int          failures;
   int          n_checks;
   int          cycles;

   // ready is held low here, so bit 8 must read zero in the compensation row
   sctl_row_type rows [9] = '{
      '{SCTL_OFF_PMCFG,  32'hff7f_ffff, 32'h0000_0000, 1'b0},
      '{SCTL_OFF_PMCFG,  32'hffff_ffff, 32'h0080_0000, 1'b0},
      '{SCTL_OFF_SRC0,   32'hffff_8765, 32'h0000_8765, 1'b0},
      '{SCTL_OFF_SRC1,   32'h0000_abcd, 32'h0000_abcd, 1'b0},
      '{SCTL_OFF_SRC2,   32'h1234_5678, 32'h0000_5678, 1'b0},
      '{SCTL_OFF_SRC3,   32'h0000_1f2e, 32'h0000_1f2e, 1'b0},
      '{SCTL_OFF_CCCTRL, 32'hffff_feff, 32'h0000_0001, 1'b0},
      '{12'h018,         32'hffff_ffff, 32'h0000_0000, 1'b1},
      '{12'h00a,         32'hffff_ffff, 32'h0000_0000, 1'b1}
   };
   logic [11:0] offs [6] = '{SCTL_OFF_PMCFG, SCTL_OFF_SRC0, SCTL_OFF_SRC1,
                             SCTL_OFF_SRC2, SCTL_OFF_SRC3, SCTL_OFF_CCCTRL};

   sctl_system_config i_sctl_system_config (
      .pclk                   (pclk),
      .presetn                (presetn),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .prdata                 (prdata),
      .port_a_pin             (pin[0]),
      .port_b_pin             (pin[1]),
      .port_c_pin             (pin[2]),
      .port_d_pin             (pin[3]),
      .port_e_pin             (pin[4]),
      .port_f_pin             (pin[5]),
      .port_g_pin             (pin[6]),
      .port_h_pin             (pin[7]),
      .port_i_pin             (pin[8]),
      .line_level             (line_level),
      .phy_interface_select   (phy_interface_select),
      .comp_cell_power_enable (comp_cell_power_enable),
      .comp_cell_ready        (comp_cell_ready)
   );

   always #4 pclk = ~pclk;

   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a hung handshake would otherwise stall the run for good
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         summarize();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic read_zero();
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, offs[i], 32'h0000_0000);
         check("reset word", rd, SCTL_RST_WORD);
      end
   endtask

   function automatic logic [15:0] exp_lines();
      logic [15:0] r;
      logic [3:0]  c;
      r = 16'h0000;
      for (int n = 0; n < 16; n++) begin
         c = src[n/4][4*(n%4) +: 4];
         if (c < 4'h8 || (c == 4'h8 && n < 12)) begin
            r[n] = pin[c][n];
         end
      end
      return r;
   endfunction

   task automatic write_src();
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, SCTL_OFF_SRC0 + 12'(4*r), {16'h0000, src[r]});
      end
   endtask

   task automatic check_lines();
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("line_level", line_level, exp_lines());
   endtask

   initial begin
      pclk            = 1'b0;
      presetn         = 1'b0;
      psel            = 1'b0;
      penable         = 1'b0;
      pwrite          = 1'b0;
      paddr           = 12'h000;
      pwdata          = 32'h0000_0000;
      comp_cell_ready = 1'b0;
      failures        = 0;
      n_checks        = 0;
      cycles          = 0;
      for (int k = 0; k < 9; k++) begin
         pin[k] = 16'h6c39 ^ (16'(k) * 16'h1357);
      end
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      read_zero();
      // phy select writes assume the ethernet side is held in reset
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0000_0000);
         check("read word", rd, rows[i].r);
         check("pslverr", {31'h0, er}, {31'h0, rows[i].e});
      end
      check("phy select", {31'h0, phy_interface_select}, 32'h1);
      check("comp enable", {31'h0, comp_cell_power_enable}, 32'h1);
      for (int c = 0; c < 16; c++) begin
         for (int r = 0; r < 4; r++) begin
            src[r] = {4{4'(c)}};
         end
         write_src();
         check_lines();
         @(posedge pclk);
         for (int k = 0; k < 9; k++) begin
            pin[k] <= ~pin[k];
         end
         check_lines();
      end
      src = '{16'h3210, 16'h7654, 16'hba98, 16'h8765};
      write_src();
      check_lines();
      @(posedge pclk);
      comp_cell_ready <= 1'b1;
      apb(1'b1, SCTL_OFF_CCCTRL, 32'h0000_0000);
      apb(1'b0, SCTL_OFF_CCCTRL, 32'h0000_0000);
      check("ready flag", rd, 32'h0000_0100);
      check("comp enable", {31'h0, comp_cell_power_enable}, 32'h0);
      apb(1'b1, SCTL_OFF_CCCTRL, 32'h0000_0001);
      // second reset in mid-run, with phy select, compensation enable and prdata away from their reset levels
      @(posedge pclk);
      presetn         <= 1'b0;
      comp_cell_ready <= 1'b0;
      @(negedge pclk);
      check("phy select", {31'h0, phy_interface_select}, 32'h0);
      check("comp enable", {31'h0, comp_cell_power_enable}, 32'h0);
      check("prdata in reset", prdata, SCTL_RST_WORD);
      check("lines in reset", {16'h0000, line_level}, SCTL_RST_WORD);
      @(posedge pclk);
      presetn <= 1'b1;
      read_zero();
      src = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      check_lines();
      summarize();
   end

endmodule
